// File: hdl/psm_manager.sv
// Purpose: Tracks sleep, idle, memory, link and graphics power states
// Assumes: IDLE_REQ is the request already resolved over all cores
// Notes: Handshakes with cache and context logic are level based
`timescale 1ns/1ps
module psm_manager
  (
    input wire logic REF_CLK, // System clock
    input wire logic RST, // Synchronous reset
    input wire psm_pkg::psm_sleep_t SLEEP_REQ, // Requested sleep state
    input wire logic SLEEP_REQ_VLD, // Sleep request strobe
    input wire psm_pkg::psm_cst_t IDLE_REQ, // Resolved idle request
    input wire psm_pkg::psm_freq_t WORKLOAD, // Operating point wanted
    input wire logic CACHE_WB_DONE, // Core caches written back
    input wire logic CTX_SAVE_DONE, // Architectural state saved
    input wire logic LLC_EMPTY, // Shared cache has no valid lines
    input wire psm_pkg::psm_mreq_t MEM_REQ, // Memory power request
    input wire logic BANK_OPEN, // At least one DRAM bank open
    input wire psm_pkg::psm_link_t PEG_LREQ, // Expansion link request
    input wire psm_pkg::psm_link_t CHL_LREQ, // Chipset link request
    input wire logic GFX_D3, // Graphics adapter in D3
    output logic EXEC_EN, // Cores may execute
    output psm_pkg::psm_freq_t FREQ_SEL, // Operating point
    output logic CACHE_WB_REQ, // Write back core caches
    output logic CORE_CLK_EN, // Core clock enable
    output logic CTX_SAVE_REQ, // Save architectural state
    output logic CORE_PWR_EN, // Core supply enable
    output logic LLC_FLUSH_REQ, // Flush shared cache ways
    output logic LLC_PWR_EN, // Shared cache supply enable
    output logic DRAM_CKE, // DRAM clock enable
    output logic DRAM_SREF, // DRAM in self-refresh
    output logic DEV_PWR_EN, // Device supply enable
    output logic DISP_EN, // Display output enable
    output logic GFX_PWR_EN, // Graphics core supply enable
    output psm_pkg::psm_sleep_t SLEEP_STATE, // Current sleep state
    output psm_pkg::psm_cst_t PKG_CSTATE, // Current package state
    output psm_pkg::psm_mem_t MEM_STATE, // Current memory state
    output psm_pkg::psm_link_t PEG_LSTATE, // Expansion link state
    output psm_pkg::psm_link_t CHL_LSTATE // Chipset link state
  );
  import psm_pkg::*;

  typedef enum logic [2:0] {
    IS_RUN = 3'h0,
    IS_FLUSH = 3'h1,
    IS_SAVE = 3'h2,
    IS_LLCFL = 3'h3,
    IS_SETTLE = 3'h4,
    IS_IDLE = 3'h5,
    IS_WAKE = 3'h6
  } psm_ist_t;

  typedef struct packed {
    psm_ist_t ist;
    psm_cst_t pkg;
    psm_cst_t tgt;
    psm_sleep_t sleep;
    psm_mem_t mem;
    psm_link_t peg;
    psm_link_t peg_tgt;
    psm_link_t chl;
    psm_link_t chl_tgt;
    psm_freq_t freq;
    logic exec;
    logic wb_req;
    logic clk_en;
    logic save_req;
    logic saved;
    logic pwr_en;
    logic llc_fl;
    logic llc_pwr;
    logic cke;
    logic sref;
    logic dev_pwr;
    logic disp;
    logic gfx_pwr;
  } psm_st_t;

  localparam psm_st_t ST_RST = '{ist: IS_RUN, pkg: CS_C0, tgt: CS_C0,
    sleep: SL_S0, mem: MS_ACTIVE, peg: LS_L0, peg_tgt: LS_L0,
    chl: LS_L0, chl_tgt: LS_L0, freq: FREQ_RST, exec: 1'b1,
    wb_req: 1'b0, clk_en: 1'b1, save_req: 1'b0, saved: 1'b0,
    pwr_en: 1'b1, llc_fl: 1'b0, llc_pwr: 1'b1, cke: 1'b1, sref: 1'b0,
    dev_pwr: 1'b1, disp: 1'b1, gfx_pwr: 1'b1};

  psm_st_t st_q;
  psm_st_t st_d;
  logic i_load;
  logic i_done;
  logic p_load;
  logic p_busy;
  logic p_done;
  logic c_load;
  logic c_busy;
  logic c_done;
  psm_cnt_t i_val;
  psm_link_t peg_want;
  psm_link_t chl_want;

  // One timer each for idle sequencing and for the two links
  psm_timer u_itmr (.clk(REF_CLK), .rst(RST), .load(i_load),
    .load_val(i_val), .busy(), .done(i_done));
  psm_timer u_ptmr (.clk(REF_CLK), .rst(RST), .load(p_load),
    .load_val(l_lat(st_q.peg, peg_want)), .busy(p_busy), .done(p_done));
  psm_timer u_ctmr (.clk(REF_CLK), .rst(RST), .load(c_load),
    .load_val(l_lat(st_q.chl, chl_want)), .busy(c_busy), .done(c_done));

  // Next-state logic for every tracked domain
  always_comb
  begin
    st_d = st_q;
    i_load = 1'b0;
    i_val = CNT_ONE;
    if (SLEEP_REQ_VLD && st_q.sleep != SL_G3)
      st_d.sleep = SLEEP_REQ;
    // Idle sequencer; a step waits for its handshake, never times out
    case (st_q.ist)
      IS_RUN:
      begin
        st_d.freq = WORKLOAD;
        // Cores resume here after a sleep returns to full-on
        st_d.exec = 1'b1;
        if (IDLE_REQ != CS_C0 && st_q.sleep == SL_S0)
        begin
          st_d.tgt = IDLE_REQ;
          st_d.exec = 1'b0;
          if (IDLE_REQ == CS_C1 || IDLE_REQ == CS_C1E)
          begin
            st_d.ist = IS_SETTLE;
            i_load = 1'b1;
            i_val = c_lat(IDLE_REQ);
          end
          else
          begin
            st_d.ist = IS_FLUSH;
            st_d.wb_req = 1'b1;
          end
        end
      end
      IS_FLUSH:
        if (CACHE_WB_DONE)
        begin
          st_d.wb_req = 1'b0;
          st_d.clk_en = 1'b0;
          if (st_q.tgt == CS_C3)
          begin
            st_d.ist = IS_SETTLE;
            i_load = 1'b1;
            i_val = c_lat(st_q.tgt);
          end
          else
          begin
            st_d.ist = IS_SAVE;
            st_d.save_req = 1'b1;
          end
        end
      IS_SAVE:
        if (CTX_SAVE_DONE)
        begin
          st_d.save_req = 1'b0;
          st_d.saved = 1'b1;
          st_d.pwr_en = 1'b0;
          if (st_q.tgt == CS_C7)
            st_d.ist = IS_LLCFL;
          else
          begin
            st_d.ist = IS_SETTLE;
            i_load = 1'b1;
            i_val = c_lat(st_q.tgt);
          end
        end
      IS_LLCFL:
      begin
        st_d.llc_fl = !LLC_EMPTY;
        if (LLC_EMPTY)
        begin
          st_d.llc_pwr = 1'b0;
          st_d.ist = IS_SETTLE;
          i_load = 1'b1;
          i_val = c_lat(st_q.tgt);
        end
      end
      IS_SETTLE:
        if (i_done)
        begin
          st_d.pkg = st_q.tgt;
          st_d.ist = IS_IDLE;
          if (st_q.tgt == CS_C1E)
            st_d.freq = FREQ_MIN;
        end
      IS_IDLE:
        if (IDLE_REQ == CS_C0 && st_q.sleep == SL_S0)
        begin
          st_d.ist = IS_WAKE;
          st_d.pwr_en = 1'b1;
          st_d.llc_pwr = 1'b1;
          i_load = 1'b1;
          i_val = c_lat(st_q.pkg);
        end
      IS_WAKE:
        // Clocks return only after supply has settled
        if (i_done)
        begin
          st_d.clk_en = 1'b1;
          st_d.saved = 1'b0;
          st_d.exec = 1'b1;
          st_d.pkg = CS_C0;
          st_d.ist = IS_RUN;
        end
      default:
        st_d = ST_RST;
    endcase
    if (st_d.sleep != SL_S0)
      st_d.exec = 1'b0;
    // sleep keeps memory contents by self-refresh
    if (st_d.sleep != SL_S0 || MEM_REQ == MR_SREF)
      st_d.mem = MS_SREF;
    else if (MEM_REQ == MR_PDOWN)
      st_d.mem = BANK_OPEN ? MS_APD : MS_PPD;
    else
      st_d.mem = MS_ACTIVE;
    st_d.cke = (st_d.mem == MS_ACTIVE);
    st_d.sref = (st_d.mem == MS_SREF);
    st_d.dev_pwr = (st_d.sleep == SL_S0);
    st_d.disp = !GFX_D3 && st_d.sleep == SL_S0;
    st_d.gfx_pwr = !(GFX_D3 && st_d.sleep != SL_S0);
    // link moves pace through their latency timers
    peg_want = (st_q.sleep != SL_S0) ? LS_L3 : PEG_LREQ;
    chl_want = (st_q.sleep != SL_S0) ? LS_L3 : CHL_LREQ;
    p_load = !p_busy && !p_done && peg_want != st_q.peg;
    c_load = !c_busy && !c_done && chl_want != st_q.chl;
    if (p_load)
      st_d.peg_tgt = peg_want;
    if (p_done)
      st_d.peg = st_q.peg_tgt;
    if (c_load)
      st_d.chl_tgt = chl_want;
    if (c_done)
      st_d.chl = st_q.chl_tgt;
  end

  // State register
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  assign SLEEP_STATE = st_q.sleep;
  assign PKG_CSTATE = st_q.pkg;
  assign MEM_STATE = st_q.mem;
  assign PEG_LSTATE = st_q.peg;
  assign CHL_LSTATE = st_q.chl;
  assign EXEC_EN = st_q.exec;
  assign FREQ_SEL = st_q.freq;
  assign CACHE_WB_REQ = st_q.wb_req;
  assign CORE_CLK_EN = st_q.clk_en;
  assign CTX_SAVE_REQ = st_q.save_req;
  assign CORE_PWR_EN = st_q.pwr_en;
  assign LLC_FLUSH_REQ = st_q.llc_fl;
  assign LLC_PWR_EN = st_q.llc_pwr;
  assign DRAM_CKE = st_q.cke;
  assign DRAM_SREF = st_q.sref;
  assign DEV_PWR_EN = st_q.dev_pwr;
  assign DISP_EN = st_q.disp;
  assign GFX_PWR_EN = st_q.gfx_pwr;

  // Checks on the sequencing and outputs
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_cke_active: assert property (
    DRAM_CKE == (MEM_STATE == MS_ACTIVE)) else $error("CKE vs state");
  a_ppd_closed: assert property (
    (MEM_STATE == MS_PPD) |-> !$past(BANK_OPEN) && !DRAM_CKE && !DRAM_SREF)
    else $error("PPD with bank open");
  a_apd_open: assert property (
    (MEM_STATE == MS_APD) |-> $past(BANK_OPEN) && !DRAM_CKE && !DRAM_SREF)
    else $error("APD without open bank");
  a_sleep_sref: assert property (
    (SLEEP_STATE != SL_S0) |-> DRAM_SREF && !DRAM_CKE)
    else $error("sleep without self-refresh");
  a_c1e_minfreq: assert property (
    (PKG_CSTATE == CS_C1E) |-> FREQ_SEL == FREQ_MIN && !EXEC_EN)
    else $error("C1E not at lowest point");
  a_clk_after_wb: assert property (
    $fell(CORE_CLK_EN) |-> $past(CACHE_WB_REQ) && $past(CACHE_WB_DONE))
    else $error("clock gated before write-back");
  a_save_then_off: assert property (
    $fell(CORE_PWR_EN) |-> $past(CTX_SAVE_REQ) && $past(CTX_SAVE_DONE))
    else $error("voltage off before save");
  a_llc_flush: assert property (
    (st_q.ist == IS_LLCFL && !LLC_EMPTY) |=> LLC_FLUSH_REQ)
    else $error("shared cache flush missing");
  a_llc_off_empty: assert property (
    $fell(LLC_PWR_EN) |-> $past(LLC_EMPTY) && PKG_CSTATE != CS_C7 ##0
    !CORE_PWR_EN) else $error("cache off while not empty");
  a_dev_pwr_off: assert property (
    (SLEEP_STATE inside {SL_S4, SL_S5, SL_G3}) |-> !DEV_PWR_EN)
    else $error("device powered in S4/S5");
  a_gfx_s3_off: assert property (
    (SLEEP_STATE == SL_S3 && $past(GFX_D3)) |-> !GFX_PWR_EN && !DISP_EN)
    else $error("graphics on in D3/S3");
  a_freq_work: assert property (
    (!$past(RST) && st_q.ist == IS_RUN && $past(st_q.ist) == IS_RUN)
    |-> FREQ_SEL == $past(WORKLOAD)) else $error("freq not from workload");
  a_c3_latency: assert property (
    $rose(st_q.ist == IS_SETTLE && st_q.tgt == CS_C3)
    |-> (PKG_CSTATE != CS_C3) [*8] ##1 1'b1)
    else $error("C3 entry too fast");
  a_peg_settle: assert property (
    $changed(PEG_LSTATE) |-> $past(p_done)) else $error("link jumped");

  c_c1e_entry: cover property ($rose(PKG_CSTATE == CS_C1E));
  c_c7_entry: cover property ($rose(PKG_CSTATE == CS_C7));
  c_wake_c6: cover property (PKG_CSTATE == CS_C6 ##1 PKG_CSTATE == CS_C0
    or $fell(PKG_CSTATE == CS_C6));
  c_s3_sref: cover property ($rose(SLEEP_STATE == SL_S3) ##1 DRAM_SREF);

endmodule

// File: hdl/psm_pkg.sv
// Purpose: Shared types, encodings and latencies of the power state manager
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Latency figures are in ns; cycle counts are derived from them
package psm_pkg;

  // System sleep states; the hot flavour of memory suspend has no code
  typedef enum logic [2:0] {
    SL_S0 = 3'h0,
    SL_S3 = 3'h1,
    SL_S4 = 3'h2,
    SL_S5 = 3'h3,
    SL_G3 = 3'h4
  } psm_sleep_t;

  // Package idle states, numerically ordered by depth
  typedef enum logic [2:0] {
    CS_C0 = 3'h0,
    CS_C1 = 3'h1,
    CS_C1E = 3'h2,
    CS_C3 = 3'h3,
    CS_C6 = 3'h4,
    CS_C7 = 3'h5
  } psm_cst_t;

  // Memory controller power states
  typedef enum logic [1:0] {
    MS_ACTIVE = 2'h0,
    MS_PPD = 2'h1,
    MS_APD = 2'h2,
    MS_SREF = 2'h3
  } psm_mem_t;

  // Memory power requests from the scheduler
  typedef enum logic [1:0] {
    MR_ACTIVE = 2'h0,
    MR_PDOWN = 2'h1,
    MR_SREF = 2'h2
  } psm_mreq_t;

  // Link states for the expansion link and the chipset_link
  typedef enum logic [1:0] {
    LS_L0 = 2'h0,
    LS_L0S = 2'h1,
    LS_L1 = 2'h2,
    LS_L3 = 2'h3
  } psm_link_t;

  localparam int CNT_W = 8;
  localparam int FREQ_W = 4;
  typedef logic [CNT_W-1:0] psm_cnt_t;
  typedef logic [FREQ_W-1:0] psm_freq_t;

  localparam psm_cnt_t CNT_ZERO = 8'h00;
  localparam psm_cnt_t CNT_ONE = 8'h01;
  localparam psm_freq_t FREQ_MIN = 4'h0;
  localparam psm_freq_t FREQ_RST = 4'h0;

  // Clock period and entry/exit latencies, deeper costs more
  localparam int CLK_NS = 10;
  localparam int C1_LAT_NS = 20;
  localparam int C3_LAT_NS = 100;
  localparam int C6_LAT_NS = 400;
  localparam int C7_LAT_NS = 1000;
  localparam int L0S_LAT_NS = 20;
  localparam int L1_LAT_NS = 200;
  localparam int L3_LAT_NS = 2000;
  localparam psm_cnt_t C1_CYC = psm_cnt_t'((C1_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t C3_CYC = psm_cnt_t'((C3_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t C6_CYC = psm_cnt_t'((C6_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t C7_CYC = psm_cnt_t'((C7_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t L0S_CYC = psm_cnt_t'((L0S_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t L1_CYC = psm_cnt_t'((L1_LAT_NS+CLK_NS-1)/CLK_NS);
  localparam psm_cnt_t L3_CYC = psm_cnt_t'((L3_LAT_NS+CLK_NS-1)/CLK_NS);

  // Entry/exit latency of an idle state
  function automatic psm_cnt_t c_lat(psm_cst_t c);
    case (c)
      CS_C1, CS_C1E: return C1_CYC;
      CS_C3: return C3_CYC;
      CS_C6: return C6_CYC;
      CS_C7: return C7_CYC;
      default: return CNT_ONE;
    endcase
  endfunction

  // Link transition cost is the latency of the deeper end
  function automatic psm_cnt_t l_lat(psm_link_t a, psm_link_t b);
    psm_link_t deep;
    deep = (a > b) ? a : b;
    case (deep)
      LS_L0S: return L0S_CYC;
      LS_L1: return L1_CYC;
      LS_L3: return L3_CYC;
      default: return CNT_ONE;
    endcase
  endfunction

endpackage

// File: hdl/psm_timer.sv
// Purpose: Down-counter that paces one state transition
// Assumes: Load value of at least one cycle
// Notes: done pulses exactly load_val cycles after the load edge
`timescale 1ns/1ps
module psm_timer
  (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic load, // Start a new count
    input wire psm_pkg::psm_cnt_t load_val, // Cycles to count
    output logic busy, // Count running
    output logic done // One-cycle end pulse
  );
  import psm_pkg::*;

  typedef struct packed {
    psm_cnt_t cnt;
    logic done;
  } psm_tmr_st_t;

  localparam psm_tmr_st_t TMR_RST = '{cnt: CNT_ZERO, done: 1'b0};

  psm_tmr_st_t st_q;
  psm_tmr_st_t st_d;

  // A load restarts the count even while one is running
  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (load)
      st_d.cnt = load_val;
    else if (st_q.cnt != CNT_ZERO)
    begin
      st_d.cnt = st_q.cnt - CNT_ONE;
      st_d.done = (st_q.cnt == CNT_ONE);
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= TMR_RST;
    else
      st_q <= st_d;
  end

  assign busy = (st_q.cnt != CNT_ZERO);
  assign done = st_q.done;

endmodule

// File: tb/psm_partner.sv
// Purpose: Far-side model: cache, context store and DRAM responders
// Assumes: Requests are levels held until their done is seen
// Notes: dly sets the reply time, so prompt and slow replies both occur
`timescale 1ns/1ps
module psm_partner
  #(
    parameter int HOLD_CYC = 1000 // Cycles DRAM keeps data unrefreshed
  )
  (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [3:0] dly, // Reply delay in cycles
    input wire logic wb_req, // Write-back request
    input wire logic ctx_req, // Context save request
    input wire logic fl_req, // Shared cache flush request
    input wire logic exec_en, // Cores running
    input wire logic cke, // DRAM clock enable
    input wire logic sref, // DRAM self-refresh
    output logic wb_done, // Write-back finished
    output logic ctx_done, // Context saved
    output logic llc_empty, // Shared cache empty
    output logic mem_ok // DRAM contents kept
  );
  typedef struct packed
  {
    logic [3:0] wb_n;
    logic [3:0] ctx_n;
    logic [3:0] fl_n;
    logic [10:0] hold_n;
    logic wb_d;
    logic ctx_d;
    logic empty;
    logic ok;
  } psm_prt_t;
  psm_prt_t s_q;
  psm_prt_t s_d;

  // Saturating count of cycles a request has been held
  function automatic logic [3:0] inc(input logic r, input logic [3:0] c);
    return !r ? 4'h0 : (c < dly) ? c + 4'h1 : c;
  endfunction

  // Replies come late on purpose; a fast reply would hide ordering slips
  always_comb
  begin
    s_d = s_q;
    s_d.wb_n = inc(wb_req, s_q.wb_n);
    s_d.ctx_n = inc(ctx_req, s_q.ctx_n);
    s_d.fl_n = inc(fl_req, s_q.fl_n);
    s_d.wb_d = wb_req && (s_q.wb_n >= dly);
    s_d.ctx_d = ctx_req && (s_q.ctx_n >= dly);
    // Running cores dirty the shared cache again
    if (exec_en)
      s_d.empty = 1'b0;
    else if (fl_req && s_q.fl_n >= dly)
      s_d.empty = 1'b1;
    if (cke || sref)
      s_d.hold_n = 11'h000;
    else if (s_q.hold_n < HOLD_CYC)
      s_d.hold_n = s_q.hold_n + 11'h001;
    else
      s_d.ok = 1'b0;
    if (rst)
      s_d = '{ok: 1'b1, default: '0};
  end

  // State register
  always_ff @(posedge clk)
    s_q <= s_d;

  assign wb_done = s_q.wb_d;
  assign ctx_done = s_q.ctx_d;
  assign llc_empty = s_q.empty;
  assign mem_ok = s_q.ok;
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the power state manager
// Assumes: Far side replies come from psm_partner
// Notes: Each status change is matched in order against a queued note
`timescale 1ns/1ps
module testbench;
  import psm_pkg::*;
  typedef struct packed
  {
    logic [24:0] v;
    logic [24:0] m;
  } psm_note_t;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  psm_sleep_t SLEEP_REQ = SL_S0;
  logic SLEEP_REQ_VLD = 1'b0;
  psm_cst_t IDLE_REQ = CS_C0;
  psm_freq_t WORKLOAD = 4'h0;
  psm_mreq_t MEM_REQ = MR_ACTIVE;
  logic BANK_OPEN = 1'b0;
  psm_link_t PEG_LREQ = LS_L0;
  psm_link_t CHL_LREQ = LS_L0;
  logic GFX_D3 = 1'b0;
  logic [3:0] dly = 4'h1;
  logic CACHE_WB_DONE, CTX_SAVE_DONE, LLC_EMPTY, mem_ok, EXEC_EN;
  logic CACHE_WB_REQ, CORE_CLK_EN, CTX_SAVE_REQ, CORE_PWR_EN, DEV_PWR_EN;
  logic LLC_FLUSH_REQ, LLC_PWR_EN, DRAM_CKE, DRAM_SREF, DISP_EN, GFX_PWR_EN;
  psm_freq_t FREQ_SEL;
  psm_sleep_t SLEEP_STATE, e_sl;
  psm_cst_t PKG_CSTATE, e_pk;
  psm_mem_t MEM_STATE, e_mm;
  psm_link_t PEG_LSTATE, CHL_LSTATE, e_pg, e_ch;
  psm_freq_t e_fq;
  int failures = 0;
  int samples_checked = 0;
  psm_note_t q [$];
  logic mon_on = 1'b0;
  logic ord_on = 1'b0;
  logic [2:0] seen;
  psm_cst_t cs [5] = '{CS_C1, CS_C1E, CS_C3, CS_C6, CS_C7};
  int cx [5] = '{C1_CYC, C1_CYC, C3_CYC, C6_CYC, C7_CYC};
  logic [2:0] sx [5] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h7};
  psm_link_t lk [4] = '{LS_L0S, LS_L1, LS_L3, LS_L0};
  int lx [4] = '{L0S_CYC, L1_CYC, L3_CYC, L3_CYC};
  psm_sleep_t sl [4] = '{SL_S3, SL_S4, SL_S5, SL_S0};
  psm_mreq_t mr [6] = '{MR_PDOWN, MR_PDOWN, MR_SREF, psm_mreq_t'(2'h3),
    MR_PDOWN, MR_ACTIVE};
  logic bk [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  psm_mem_t ms [6] = '{MS_PPD, MS_APD, MS_SREF, MS_ACTIVE, MS_APD, MS_ACTIVE};

  psm_manager dut_u (.REF_CLK(REF_CLK), .RST(RST), .SLEEP_REQ(SLEEP_REQ),
    .SLEEP_REQ_VLD(SLEEP_REQ_VLD), .IDLE_REQ(IDLE_REQ), .WORKLOAD(WORKLOAD),
    .CACHE_WB_DONE(CACHE_WB_DONE), .CTX_SAVE_DONE(CTX_SAVE_DONE),
    .LLC_EMPTY(LLC_EMPTY), .MEM_REQ(MEM_REQ), .BANK_OPEN(BANK_OPEN),
    .PEG_LREQ(PEG_LREQ), .CHL_LREQ(CHL_LREQ), .GFX_D3(GFX_D3),
    .EXEC_EN(EXEC_EN), .FREQ_SEL(FREQ_SEL), .CACHE_WB_REQ(CACHE_WB_REQ),
    .CORE_CLK_EN(CORE_CLK_EN), .CTX_SAVE_REQ(CTX_SAVE_REQ),
    .CORE_PWR_EN(CORE_PWR_EN), .LLC_FLUSH_REQ(LLC_FLUSH_REQ),
    .LLC_PWR_EN(LLC_PWR_EN), .DRAM_CKE(DRAM_CKE), .DRAM_SREF(DRAM_SREF),
    .DEV_PWR_EN(DEV_PWR_EN), .DISP_EN(DISP_EN), .GFX_PWR_EN(GFX_PWR_EN),
    .SLEEP_STATE(SLEEP_STATE), .PKG_CSTATE(PKG_CSTATE),
    .MEM_STATE(MEM_STATE), .PEG_LSTATE(PEG_LSTATE), .CHL_LSTATE(CHL_LSTATE));

  psm_partner prt_u (.clk(REF_CLK), .rst(RST), .dly(dly),
    .wb_req(CACHE_WB_REQ), .ctx_req(CTX_SAVE_REQ), .fl_req(LLC_FLUSH_REQ),
    .exec_en(EXEC_EN), .cke(DRAM_CKE), .sref(DRAM_SREF),
    .wb_done(CACHE_WB_DONE), .ctx_done(CTX_SAVE_DONE),
    .llc_empty(LLC_EMPTY), .mem_ok(mem_ok));

  // Free-running 100 MHz clock
  initial
    forever
      #5 REF_CLK = ~REF_CLK;

  function automatic logic [11:0] st();
    return {SLEEP_STATE, PKG_CSTATE, MEM_STATE, PEG_LSTATE, CHL_LSTATE};
  endfunction

  task automatic fail(input string msg);
    failures++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
      fail(msg);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  // Pins: exec, clk, core pwr, llc pwr, cke, sref, dev, disp, gfx
  task automatic note(input logic [8:0] p, input logic [8:0] pm,
      input logic fm);
    psm_note_t n;
    n.v = {e_sl, e_pk, e_mm, e_pg, e_ch, e_fq, p};
    n.m = {12'hFFF, {4{fm}}, pm};
    q.push_back(n);
  endtask

  task automatic end_of_test;
    if (q.size() != 0)
      fail("expected changes never came");
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Waits for a status change, watching handshake order meanwhile
  task automatic wt(input int lim, output int n);
    logic [11:0] s0;
    s0 = st();
    n = 0;
    while (st() === s0)
    begin
      tick(1);
      n++;
      seen |= {LLC_FLUSH_REQ === 1'b1, CTX_SAVE_REQ === 1'b1,
        CACHE_WB_REQ === 1'b1};
      if (ord_on)
      begin
        chk(!(CACHE_WB_REQ === 1'b1 && CORE_CLK_EN !== 1'b1), "clk off");
        chk(!(CTX_SAVE_REQ === 1'b1 && CORE_PWR_EN !== 1'b1), "pwr off");
        chk(!(LLC_EMPTY === 1'b0 && LLC_PWR_EN !== 1'b1), "llc off");
      end
      if (n >= lim && st() === s0)
      begin
        fail("wait for status change timed out");
        end_of_test();
      end
    end
  endtask

  // Takes the oldest note whenever the status outputs move
  initial
  begin : mon
    logic [24:0] cur;
    logic [11:0] prv;
    psm_note_t n;
    prv = 12'h000;
    forever
    begin
      @(negedge REF_CLK);
      cur = {st(), FREQ_SEL, EXEC_EN, CORE_CLK_EN, CORE_PWR_EN, LLC_PWR_EN,
        DRAM_CKE, DRAM_SREF, DEV_PWR_EN, DISP_EN, GFX_PWR_EN};
      if (mon_on && cur[24:13] !== prv)
      begin
        samples_checked++;
        n = q.size() > 0 ? q.pop_front() : '0;
        if ((cur & n.m) !== (n.v & n.m) || n.m == '0)
          fail("status change does not match note");
      end
      prv = cur[24:13];
    end
  end

  // Main sequence
  initial
  begin : main
    int n;
    int lat [5];
    logic [8:0] p;
    logic [8:0] pm;
    n = $urandom(32'hCD53C23B);
    {e_sl, e_pk, e_mm, e_pg, e_ch, e_fq} = '0;
    tick(20);
    chk({st(), FREQ_SEL, EXEC_EN, CORE_CLK_EN, CORE_PWR_EN, LLC_PWR_EN,
      DRAM_CKE, DRAM_SREF, DEV_PWR_EN, DISP_EN, GFX_PWR_EN}
      === {12'h000, FREQ_RST, 9'h1F7}, "reset values");
    RST = 1'b0;
    mon_on = 1'b1;
    tick(2);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      WORKLOAD = 4'($urandom);
      tick(2);
      e_fq = WORKLOAD;
      e_mm = ms[i];
      note({4'hF, ms[i] == MS_ACTIVE, ms[i] == MS_SREF, 3'h7}, 9'h1FF,
        1'b1);
      MEM_REQ = mr[i];
      BANK_OPEN = bk[i];
      wt(5, n);
      chk(n === 1, "memory state late");
    end
    $display("test memory done");
    ord_on = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      dly = 4'($urandom_range(1, 6));
      seen = 3'h0;
      e_pk = cs[i];
      e_fq = FREQ_MIN;
      note({2'h0, cs[i] < CS_C6, cs[i] != CS_C7, 5'h17},
        (i < 2) ? 9'h17F : 9'h1FF, cs[i] == CS_C1E);
      IDLE_REQ = cs[i];
      wt(400, lat[i]);
      chk(seen === sx[i], "handshakes");
      if (i < 2)
        chk(lat[i] === cx[i] + 2, "halt entry time");
      else
        chk(lat[i] > lat[i-1], "deeper entry not longer");
      e_pk = CS_C0;
      note(9'h1F7, 9'h1FF, 1'b0);
      IDLE_REQ = CS_C0;
      wt(400, n);
      chk(n === cx[i] + 2, "exit time");
      tick(2);
    end
    ord_on = 1'b0;
    e_fq = WORKLOAD;
    $display("test idle done");
    for (int i = 0; i < 4; i++)
    begin
      e_pg = lk[i];
      e_ch = lk[i];
      note(9'h1F7, 9'h1FF, 1'b1);
      PEG_LREQ = lk[i];
      CHL_LREQ = lk[i];
      wt(300, n);
      chk(n === lx[i] + 2, "link move time");
      tick(2);
    end
    $display("test link done");
    e_mm = MS_SREF;
    note(9'h1EF, 9'h1FF, 1'b1);
    MEM_REQ = MR_SREF;
    wt(5, n);
    for (int i = 0; i < 5; i++)
    begin
      GFX_D3 = 1'($urandom);
      tick(2);
      e_sl = (i < 4) ? sl[i] : SL_G3;
      p = (e_sl == SL_S0) ? {1'b1, 5'h01, 1'b1, !GFX_D3, 1'b1} :
        {6'h01, 2'h0, !GFX_D3};
      pm = 9'h11F;
      note(p, pm, 1'b0);
      SLEEP_REQ = e_sl;
      SLEEP_REQ_VLD = 1'b1;
      wt(5, n);
      SLEEP_REQ_VLD = 1'b0;
      chk(n === 1, "sleep state late");
      if (i == 0 || i >= 3)
      begin
        e_pg = (e_sl == SL_S0) ? LS_L0 : LS_L3;
        e_ch = e_pg;
        note(p, pm, 1'b0);
        wt(300, n);
      end
    end
    SLEEP_REQ = SL_S0;
    SLEEP_REQ_VLD = 1'b1;
    tick(3);
    SLEEP_REQ_VLD = 1'b0;
    chk(SLEEP_STATE === SL_G3, "left mechanical off");
    chk(mem_ok === 1'b1, "DRAM contents lost");
    $display("test sleep done");
    {e_sl, e_pk, e_mm, e_pg, e_ch, e_fq} = '0;
    note(9'h1F7, 9'h1FF, 1'b1);
    RST = 1'b1;
    MEM_REQ = MR_ACTIVE;
    tick(3);
    RST = 1'b0;
    tick(3);
    end_of_test();
  end
endmodule
